// ---- hw/spr_pkg.sv ----
// shared constants and types of the submessage parser
package spr_pkg;

	// =========================================================
	// header layout
	localparam logic [31:0] HDR_BYTES      = 32'h0000_0004;
	localparam logic [1:0]  IDX_KIND       = 2'h0;
	localparam logic [1:0]  IDX_FLAGS      = 2'h1;
	localparam logic [1:0]  IDX_LEN_A      = 2'h2;
	localparam logic [1:0]  IDX_LEN_B      = 2'h3;
	localparam int          FLAG_ORDER_POS = 0;

	// =========================================================
	// kind codes and their meaningful flags (values arbitrary)
	localparam logic [7:0] KIND_PAD      = 8'h01;
	localparam logic [7:0] KIND_ACK_REQ  = 8'h06;
	localparam logic [7:0] KIND_BEAT     = 8'h07;
	localparam logic [7:0] KIND_GAP      = 8'h08;
	localparam logic [7:0] KIND_TIME     = 8'h09;
	localparam logic [7:0] KIND_SRC      = 8'h0C;
	localparam logic [7:0] KIND_REPLY    = 8'h0F;
	localparam logic [7:0] KIND_DST      = 8'h0E;
	localparam logic [7:0] KIND_DATA     = 8'h15;
	localparam logic [7:0] KIND_FRAG     = 8'h16;
	localparam logic [7:0] MASK_ORDER    = 8'h01;
	localparam logic [7:0] MASK_ONE      = 8'h03;
	localparam logic [7:0] MASK_TWO      = 8'h07;
	localparam logic [7:0] MASK_FOUR     = 8'h1F;
	localparam logic [7:0] MASK_NONE     = 8'h00;

	// =========================================================
	// receiver context initial values (values arbitrary)
	localparam logic [15:0]  VERSION_CURRENT = 16'h0201;
	localparam logic [15:0]  MAKER_CODE_NONE = 16'h0000;
	localparam logic [95:0]  ID_PREFIX_NONE  = 96'h0;
	localparam logic [127:0] ADDR_INVALID    = 128'h0;
	localparam logic [31:0]  PORT_INVALID    = 32'h0000_0000;
	localparam logic [63:0]  TIME_INVALID    = 64'hFFFF_FFFF_FFFF_FFFF;

	// context field selects for updates
	localparam logic [3:0] SEL_VERSION = 4'h0;
	localparam logic [3:0] SEL_MAKER   = 4'h1;
	localparam logic [3:0] SEL_SRC_PFX = 4'h2;
	localparam logic [3:0] SEL_DST_PFX = 4'h3;
	localparam logic [3:0] SEL_UC_ADDR = 4'h4;
	localparam logic [3:0] SEL_UC_PORT = 4'h5;
	localparam logic [3:0] SEL_MC_ADDR = 4'h6;
	localparam logic [3:0] SEL_MC_PORT = 4'h7;
	localparam logic [3:0] SEL_TIME    = 4'h8;

	// =========================================================
	// registers
	localparam logic [7:0]  REG_STATUS  = 8'h00;
	localparam logic [7:0]  REG_MASK    = 8'h04;
	localparam logic [7:0]  REG_CTRL    = 8'h08;
	localparam logic [7:0]  REG_PARTS   = 8'h0C;
	localparam logic [4:0]  STATUS_RST  = 5'h00;
	localparam logic [4:0]  MASK_RST    = 5'h00;
	localparam logic        CTRL_RST    = 1'b1;
	localparam int          EV_DONE     = 0;
	localparam int          EV_TRUNC    = 1;
	localparam int          EV_BAD_LEN  = 2;
	localparam int          EV_SKIP     = 3;
	localparam int          EV_INVALID  = 4;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HDR  = 2'b01,
		ST_BODY = 2'b10,
		ST_DROP = 2'b11
	} spr_state_t;

	// flags that carry meaning for a kind; zero for unknown kinds
	function automatic logic [7:0] spr_kind_mask(input logic [7:0] kind);
		unique case (kind)
			KIND_PAD, KIND_SRC, KIND_DST: spr_kind_mask = MASK_ORDER;
			KIND_ACK_REQ, KIND_BEAT, KIND_TIME, KIND_REPLY:
				spr_kind_mask = MASK_ONE;
			KIND_GAP:  spr_kind_mask = MASK_TWO;
			KIND_DATA, KIND_FRAG: spr_kind_mask = MASK_FOUR;
			default:   spr_kind_mask = MASK_NONE;
		endcase
	endfunction : spr_kind_mask

	// length from its two bytes in arrival order
	function automatic logic [15:0] spr_len(input logic little,
		input logic [7:0] first, input logic [7:0] second);
		spr_len = little ? {second, first} : {first, second};
	endfunction : spr_len

endpackage : spr_pkg

// ---- hw/spr_ctx_if.sv ----
// receiver context signals between parser and context store
`timescale 1ns/100ps
interface spr_ctx_if;
	import spr_pkg::*;
	logic          init;
	logic [95:0]   local_prefix;
	logic [31:0]   xport_kind;
	logic          src_ok;
	logic [127:0]  src_addr;
	logic          wr;
	logic [3:0]    sel;
	logic [127:0]  wdata;
	logic [15:0]   version;
	logic [15:0]   maker;
	logic [95:0]   src_pfx;
	logic [95:0]   dst_pfx;
	logic [31:0]   uc_kind;
	logic [127:0]  uc_addr;
	logic [31:0]   uc_port;
	logic [31:0]   mc_kind;
	logic [127:0]  mc_addr;
	logic [31:0]   mc_port;
	logic          time_ok;
	logic [63:0]   time_val;

	modport owner (output init, local_prefix, xport_kind, src_ok, src_addr,
		wr, sel, wdata, input version, maker, src_pfx, dst_pfx, uc_kind,
		uc_addr, uc_port, mc_kind, mc_addr, mc_port, time_ok, time_val);
	modport store (input init, local_prefix, xport_kind, src_ok, src_addr,
		wr, sel, wdata, output version, maker, src_pfx, dst_pfx, uc_kind,
		uc_addr, uc_port, mc_kind, mc_addr, mc_port, time_ok, time_val);
endinterface : spr_ctx_if

// ---- hw/spr_ctx.sv ----
// per-message receiver context store
`timescale 1ns/100ps
module spr_ctx
	import spr_pkg::*;
(
	// clock and reset
	input  wire logic  i_sys_clk,
	input  wire logic  i_nrst,
	// context
	spr_ctx_if.store   c
);

	// =========================================================
	// context next state
	logic [15:0]  ver_q,  ver_d;
	logic [15:0]  mk_q,   mk_d;
	logic [95:0]  sp_q,   sp_d;
	logic [95:0]  dp_q,   dp_d;
	logic [31:0]  uk_q,   uk_d;
	logic [127:0] ua_q,   ua_d;
	logic [31:0]  up_q,   up_d;
	logic [31:0]  mkd_q,  mkd_d;
	logic [127:0] ma_q,   ma_d;
	logic [31:0]  mp_q,   mp_d;
	logic         tok_q,  tok_d;
	logic [63:0]  tv_q,   tv_d;

	always_comb begin
		{ver_d, mk_d, sp_d, dp_d} = {ver_q, mk_q, sp_q, dp_q};
		{uk_d, ua_d, up_d, mkd_d, ma_d, mp_d} =
			{uk_q, ua_q, up_q, mkd_q, ma_q, mp_q};
		{tok_d, tv_d} = {tok_q, tv_q};
		if (c.init) begin
			ver_d = VERSION_CURRENT;
			mk_d  = MAKER_CODE_NONE;
			sp_d  = ID_PREFIX_NONE;
			dp_d  = c.local_prefix;
			uk_d  = c.xport_kind;
			ua_d  = c.src_ok ? c.src_addr : ADDR_INVALID;
			up_d  = PORT_INVALID;
			mkd_d = c.xport_kind;
			ma_d  = ADDR_INVALID;
			mp_d  = PORT_INVALID;
			tok_d = 1'b0;
			tv_d  = TIME_INVALID;
		end else if (c.wr) begin
			// later parts refine context of the same message
			unique case (c.sel)
				SEL_VERSION: ver_d = c.wdata[15:0];
				SEL_MAKER:   mk_d  = c.wdata[15:0];
				SEL_SRC_PFX: sp_d  = c.wdata[95:0];
				SEL_DST_PFX: dp_d  = c.wdata[95:0];
				SEL_UC_ADDR: ua_d  = c.wdata;
				SEL_UC_PORT: up_d  = c.wdata[31:0];
				SEL_MC_ADDR: ma_d  = c.wdata;
				SEL_MC_PORT: mp_d  = c.wdata[31:0];
				SEL_TIME: begin
					tok_d = 1'b1;
					tv_d  = c.wdata[63:0];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			{ver_q, mk_q, sp_q, dp_q} <=
				{VERSION_CURRENT, MAKER_CODE_NONE, ID_PREFIX_NONE, ID_PREFIX_NONE};
			{uk_q, ua_q, up_q} <= {32'h0000_0000, ADDR_INVALID, PORT_INVALID};
			{mkd_q, ma_q, mp_q} <= {32'h0000_0000, ADDR_INVALID, PORT_INVALID};
			{tok_q, tv_q} <= {1'b0, TIME_INVALID};
		end else begin
			{ver_q, mk_q, sp_q, dp_q} <= {ver_d, mk_d, sp_d, dp_d};
			{uk_q, ua_q, up_q, mkd_q, ma_q, mp_q} <=
				{uk_d, ua_d, up_d, mkd_d, ma_d, mp_d};
			{tok_q, tv_q} <= {tok_d, tv_d};
		end
	end

	assign c.version  = ver_q;
	assign c.maker    = mk_q;
	assign c.src_pfx  = sp_q;
	assign c.dst_pfx  = dp_q;
	assign c.uc_kind  = uk_q;
	assign c.uc_addr  = ua_q;
	assign c.uc_port  = up_q;
	assign c.mc_kind  = mkd_q;
	assign c.mc_addr  = ma_q;
	assign c.mc_port  = mp_q;
	assign c.time_ok  = tok_q;
	assign c.time_val = tv_q;

	// =========================================================
	// checks
	property p_init_ctx;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		c.init |=> (ver_q == VERSION_CURRENT) && (mk_q == MAKER_CODE_NONE)
			&& (sp_q == ID_PREFIX_NONE) && (dp_q == $past(c.local_prefix));
	endproperty
	a_init_ctx: assert property (p_init_ctx)
		else $error("context not initialised at message start");

	property p_init_uc;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		c.init |=> (up_q == PORT_INVALID) && (uk_q == $past(c.xport_kind))
			&& (ua_q == ($past(c.src_ok) ? $past(c.src_addr) : ADDR_INVALID));
	endproperty
	a_init_uc: assert property (p_init_uc)
		else $error("single reply target wrong at message start");

	property p_init_mc;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		c.init |=> (ma_q == ADDR_INVALID) && (mp_q == PORT_INVALID)
			&& (mkd_q == $past(c.xport_kind));
	endproperty
	a_init_mc: assert property (p_init_mc)
		else $error("group reply target wrong at message start");

	property p_init_time;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		c.init ##1 (!c.init && !(c.wr && c.sel == SEL_TIME))
			|-> !tok_q && (tv_q == TIME_INVALID);
	endproperty
	a_init_time: assert property (p_init_time)
		else $error("time mark present after message start");

endmodule : spr_ctx

// ---- hw/spr_parser.sv ----
// submessage parser with receiver context and register port
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/100ps
module spr_parser
	import spr_pkg::*;
(
	// clock and reset
	input  wire logic          i_sys_clk,
	input  wire logic          i_nrst,
	// register port
	input  wire logic [7:0]    i_reg_addr,
	input  wire logic [31:0]   i_reg_wdata,
	input  wire logic          i_reg_wr,
	input  wire logic          i_reg_rd,
	output logic      [31:0]   o_reg_rdata,
	output logic               o_irq,
	// message stream
	input  wire logic          i_msg_start,
	input  wire logic [31:0]   i_msg_len,
	input  wire logic          i_byte_valid,
	input  wire logic [7:0]    i_byte_data,
	output logic               o_byte_ready,
	// part header out
	output logic               o_hdr_valid,
	output logic      [7:0]    o_part_kind_code,
	output logic      [7:0]    o_part_flags,
	output logic               o_byte_order_flag,
	output logic      [31:0]   o_part_body_length,
	output logic               o_part_last,
	output logic               o_part_known,
	// part body out
	output logic               o_body_valid,
	output logic      [7:0]    o_body_byte,
	output logic               o_body_end,
	// element decoder feedback
	input  wire logic          i_part_invalid,
	input  wire logic          i_ctx_wr,
	input  wire logic [3:0]    i_ctx_sel,
	input  wire logic [127:0]  i_ctx_wdata,
	// local and transport facts
	input  wire logic [95:0]   i_local_id_prefix,
	input  wire logic [31:0]   i_xport_kind,
	input  wire logic          i_src_addr_ok,
	input  wire logic [127:0]  i_src_addr,
	// receiver context
	output logic      [15:0]   o_sender_protocol_version,
	output logic      [15:0]   o_sender_maker_code,
	output logic      [95:0]   o_sender_id_prefix,
	output logic      [95:0]   o_target_id_prefix,
	output logic      [31:0]   o_single_reply_kind,
	output logic      [127:0]  o_single_reply_addr,
	output logic      [31:0]   o_single_reply_port,
	output logic      [31:0]   o_group_reply_kind,
	output logic      [127:0]  o_group_reply_addr,
	output logic      [31:0]   o_group_reply_port,
	output logic               o_time_mark_present,
	output logic      [63:0]   o_time_mark
);

	// =========================================================
	// parser state
	spr_state_t   state_q, state_d;
	logic [31:0]  rem_q,   rem_d;
	logic [1:0]   idx_q,   idx_d;
	logic [7:0]   kind_q,  kind_d;
	logic [7:0]   flg_q,   flg_d;
	logic [7:0]   lena_q,  lena_d;
	logic [31:0]  body_q,  body_d;
	logic         skip_q,  skip_d;
	logic [15:0]  parts_q, parts_d;
	logic         hv_q,    hv_d;
	logic [7:0]   hk_q,    hk_d;
	logic [7:0]   hf_q,    hf_d;
	logic [31:0]  hl_q,    hl_d;
	logic         hlast_q, hlast_d;
	logic         hkn_q,   hkn_d;
	logic         bv_q,    bv_d;
	logic [7:0]   bb_q,    bb_d;
	logic         be_q,    be_d;
	logic [4:0]   ev;
	logic         take;
	logic         start;
	logic         ctrl_en_q;
	logic [15:0]  raw_len;
	logic [31:0]  after;
	logic [31:0]  size;
	logic [7:0]   mask;

	assign start        = i_msg_start && ctrl_en_q;
	assign o_byte_ready = (state_q != ST_IDLE) && !start;
	assign take         = i_byte_valid && o_byte_ready;
	// length bytes in the order set by flag zero
	assign raw_len = spr_len(flg_q[FLAG_ORDER_POS], lena_q, i_byte_data);
	assign after   = rem_q - 32'h0000_0001;
	// zero length runs to message end
	assign size    = (raw_len == 16'h0000) ? after : {16'h0000, raw_len};
	assign mask    = spr_kind_mask(kind_q);

	always_comb begin
		state_d = state_q;
		rem_d   = take ? rem_q - 32'h0000_0001 : rem_q;
		{idx_d, kind_d, flg_d, lena_d} = {idx_q, kind_q, flg_q, lena_q};
		{body_d, skip_d, parts_d} = {body_q, skip_q, parts_q};
		{hk_d, hf_d, hl_d, hlast_d, hkn_d} =
			{hk_q, hf_q, hl_q, hlast_q, hkn_q};
		hv_d = 1'b0;
		bv_d = 1'b0;
		bb_d = bb_q;
		be_d = 1'b0;
		ev   = 5'h00;
		if (start) begin
			// new message restarts parsing and context
			state_d = ST_HDR;
			rem_d   = i_msg_len;
			idx_d   = IDX_KIND;
			parts_d = 16'h0000;
		end else begin
			unique case (state_q)
				ST_IDLE: ;
				ST_HDR: begin
					if (i_part_invalid) begin
						state_d         = ST_DROP;
						ev[EV_INVALID]  = 1'b1;
					end else if (idx_q == IDX_KIND && rem_q < HDR_BYTES) begin
						state_d       = ST_DROP;
						ev[EV_TRUNC]  = 1'b1;
					end else if (take) begin
						idx_d = idx_q + 2'h1;
						unique case (idx_q)
							IDX_KIND:  kind_d = i_byte_data;
							IDX_FLAGS: flg_d  = i_byte_data;
							IDX_LEN_A: lena_d = i_byte_data;
							IDX_LEN_B: begin
								if (raw_len != 16'h0000
									&& {16'h0000, raw_len} > after) begin
									state_d        = ST_DROP;
									ev[EV_BAD_LEN] = 1'b1;
								end else begin
									hv_d    = 1'b1;
									hk_d    = kind_q;
									// unknown flags hidden per kind
									hf_d    = flg_q & (mask | MASK_ORDER);
									hl_d    = size;
									// equal to the rest means last
									hlast_d = (size == after);
									hkn_d   = (mask != MASK_NONE);
									skip_d  = (mask == MASK_NONE);
									ev[EV_SKIP] = (mask == MASK_NONE);
									parts_d = parts_q + 16'h0001;
									// header follows body by length
									body_d  = size;
									state_d = (size == 32'h0000_0000) ?
										ST_HDR : ST_BODY;
								end
							end
							default: ;
						endcase
					end
				end
				ST_BODY: begin
					if (i_part_invalid) begin
						state_d        = ST_DROP;
						ev[EV_INVALID] = 1'b1;
					end else if (take) begin
						body_d = body_q - 32'h0000_0001;
						bv_d   = !skip_q;
						bb_d   = i_byte_data;
						be_d   = !skip_q && (body_q == 32'h0000_0001);
						if (body_q == 32'h0000_0001) begin
							state_d = ST_HDR;
							idx_d   = IDX_KIND;
						end
					end
				end
				ST_DROP: ;
				default: ;
			endcase
			// message ends when its byte count is spent
			if (state_d != ST_IDLE && rem_d == 32'h0000_0000) begin
				state_d = ST_IDLE;
			end
			if (state_q != ST_IDLE && state_d == ST_IDLE) begin
				ev[EV_DONE] = 1'b1;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			state_q <= ST_IDLE;
			{rem_q, idx_q, kind_q, flg_q, lena_q} <= '0;
			{body_q, skip_q, parts_q} <= '0;
			{hv_q, hk_q, hf_q, hl_q, hlast_q, hkn_q} <= '0;
			{bv_q, bb_q, be_q} <= '0;
		end else begin
			state_q <= state_d;
			{rem_q, idx_q, kind_q, flg_q, lena_q} <=
				{rem_d, idx_d, kind_d, flg_d, lena_d};
			{body_q, skip_q, parts_q} <= {body_d, skip_d, parts_d};
			{hv_q, hk_q, hf_q, hl_q, hlast_q, hkn_q} <=
				{hv_d, hk_d, hf_d, hl_d, hlast_d, hkn_d};
			{bv_q, bb_q, be_q} <= {bv_d, bb_d, be_d};
		end
	end

	assign o_hdr_valid        = hv_q;
	assign o_part_kind_code   = hk_q;
	assign o_part_flags       = hf_q;
	assign o_byte_order_flag  = hf_q[FLAG_ORDER_POS];
	assign o_part_body_length = hl_q;
	assign o_part_last        = hlast_q;
	assign o_part_known       = hkn_q;
	assign o_body_valid       = bv_q;
	assign o_body_byte        = bb_q;
	assign o_body_end         = be_q;

	// =========================================================
	// registers and interrupt
	logic [4:0]   status_q, status_d;
	logic [4:0]   mask_q,   mask_d;
	logic         ctrl_en_d;
	logic [31:0]  rdata_q,  rdata_d;

	always_comb begin
		status_d  = status_q;
		mask_d    = mask_q;
		ctrl_en_d = ctrl_en_q;
		rdata_d   = 32'h0000_0000;
		if (i_reg_wr && i_reg_addr == REG_STATUS) begin
			status_d = status_q & ~i_reg_wdata[4:0];
		end
		status_d = status_d | ev;
		if (i_reg_wr && i_reg_addr == REG_MASK) begin
			mask_d = i_reg_wdata[4:0];
		end
		if (i_reg_wr && i_reg_addr == REG_CTRL) begin
			ctrl_en_d = i_reg_wdata[0];
		end
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				REG_STATUS: rdata_d = {27'h0, status_q};
				REG_MASK:   rdata_d = {27'h0, mask_q};
				REG_CTRL:   rdata_d = {31'h0, ctrl_en_q};
				REG_PARTS:  rdata_d = {14'h0, state_q, parts_q};
				default:    rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			status_q  <= STATUS_RST;
			mask_q    <= MASK_RST;
			ctrl_en_q <= CTRL_RST;
			rdata_q   <= 32'h0000_0000;
		end else begin
			status_q  <= status_d;
			mask_q    <= mask_d;
			ctrl_en_q <= ctrl_en_d;
			rdata_q   <= rdata_d;
		end
	end

	assign o_reg_rdata = rdata_q;
	assign o_irq       = |(status_q & mask_q);

	// =========================================================
	// receiver context
	spr_ctx_if ctx ();

	assign ctx.init         = start;
	assign ctx.local_prefix = i_local_id_prefix;
	assign ctx.xport_kind   = i_xport_kind;
	assign ctx.src_ok       = i_src_addr_ok;
	assign ctx.src_addr     = i_src_addr;
	assign ctx.wr           = i_ctx_wr;
	assign ctx.sel          = i_ctx_sel;
	assign ctx.wdata        = i_ctx_wdata;

	spr_ctx u_ctx (
		.i_sys_clk (i_sys_clk),
		.i_nrst    (i_nrst),
		.c         (ctx.store)
	);

	assign o_sender_protocol_version = ctx.version;
	assign o_sender_maker_code       = ctx.maker;
	assign o_sender_id_prefix        = ctx.src_pfx;
	assign o_target_id_prefix        = ctx.dst_pfx;
	assign o_single_reply_kind       = ctx.uc_kind;
	assign o_single_reply_addr       = ctx.uc_addr;
	assign o_single_reply_port       = ctx.uc_port;
	assign o_group_reply_kind        = ctx.mc_kind;
	assign o_group_reply_addr        = ctx.mc_addr;
	assign o_group_reply_port        = ctx.mc_port;
	assign o_time_mark_present       = ctx.time_ok;
	assign o_time_mark               = ctx.time_val;

	// =========================================================
	// checks
	sequence s_len_byte;
		state_q == ST_HDR && idx_q == IDX_LEN_B && take && !i_part_invalid;
	endsequence

	property p_order_flag;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		s_len_byte |=> !o_hdr_valid
			|| (o_byte_order_flag == $past(flg_q[FLAG_ORDER_POS]));
	endproperty
	a_order_flag: assert property (p_order_flag)
		else $error("byte order flag lost");

	property p_len_order;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		s_len_byte ##1 (o_hdr_valid && !o_part_last) |->
			o_part_body_length == {16'h0000, $past(raw_len)};
	endproperty
	a_len_order: assert property (p_len_order)
		else $error("body length decoded in wrong byte order");

	property p_flag_mask;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		o_hdr_valid |-> (o_part_flags
			& ~(spr_kind_mask(o_part_kind_code) | MASK_ORDER)) == 8'h00;
	endproperty
	a_flag_mask: assert property (p_flag_mask)
		else $error("flag shown that the kind does not define");

	property p_zero_last;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		s_len_byte ##0 (raw_len == 16'h0000) |=> o_hdr_valid && o_part_last;
	endproperty
	a_zero_last: assert property (p_zero_last)
		else $error("zero length part not marked last");

	property p_next_hdr;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		s_len_byte ##0 (raw_len != 16'h0000 && {16'h0000, raw_len} < after)
			|=> state_q == ST_BODY && body_q == {16'h0000, $past(raw_len)};
	endproperty
	a_next_hdr: assert property (p_next_hdr)
		else $error("next header not placed by length");

	property p_trunc;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		ev[EV_TRUNC] |-> rem_q < HDR_BYTES && !o_hdr_valid ##1
			(state_q == ST_DROP || state_q == ST_IDLE);
	endproperty
	a_trunc: assert property (p_trunc)
		else $error("short header not dropped");

	property p_bad_len;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		ev[EV_BAD_LEN] && !start |=> !o_hdr_valid
			&& (state_q == ST_DROP || state_q == ST_IDLE);
	endproperty
	a_bad_len: assert property (p_bad_len)
		else $error("bad length not dropped");

	property p_skip;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		state_q == ST_BODY && skip_q |=> !o_body_valid;
	endproperty
	a_skip: assert property (p_skip)
		else $error("unknown kind body forwarded");

	property p_invalid;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		ev[EV_INVALID] && !start |=> (!o_body_valid && !o_hdr_valid) [*2];
	endproperty
	a_invalid: assert property (p_invalid)
		else $error("parts forwarded after invalid part");

endmodule : spr_parser

// ---- bench/spr_sender.sv ----
// remote sender model feeding message bytes
`timescale 1ns/100ps
module spr_sender (
	// clock
	input  wire logic	i_sys_clk,
	// byte stream
	input  wire logic	i_ready,
	output logic		o_valid,
	output logic [7:0]	o_data
);
	logic	hung;
	initial begin
		o_valid = 1'b0;
		o_data = 8'h00;
		hung = 1'b0;
	end
	// ====
	// byte held until taken
	task automatic send(input logic [7:0] b);
		int n;
		n = 0;
		o_valid <= 1'b1;
		o_data <= b;
		do @(negedge i_sys_clk); while (!i_ready && ++n < 64);
		hung |= (n >= 64);
		@(posedge i_sys_clk);
	endtask : send
	// released line shows inverse
	task automatic rest();
		o_valid <= 1'b0;
		o_data <= ~o_data;
	endtask : rest
endmodule : spr_sender

// ---- bench/spr_parser_tb.sv ----
// self-checking bench of the submessage parser
`timescale 1ns/100ps
module spr_parser_tb;
	import spr_pkg::*;
	logic	i_sys_clk = 1'b0, i_nrst = 1'b0, i_reg_wr = 1'b0;
	logic	i_reg_rd = 1'b0, i_msg_start = 1'b0, i_ctx_wr = 1'b0;
	logic	i_part_invalid = 1'b0, i_src_addr_ok = 1'b1, i_byte_valid;
	logic	o_byte_ready, o_irq, o_hdr_valid, o_byte_order_flag;
	logic	o_part_last, o_part_known, o_body_valid, o_body_end;
	logic	o_time_mark_present;
	logic [7:0]	i_reg_addr = 8'h00, i_byte_data, o_part_kind_code;
	logic [7:0]	o_part_flags, o_body_byte;
	logic [3:0]	i_ctx_sel = 4'h0;
	logic [15:0]	o_sender_protocol_version, o_sender_maker_code;
	logic [31:0]	i_reg_wdata = 32'h0, i_msg_len = 32'h0, o_reg_rdata;
	logic [31:0]	i_xport_kind = 32'h0000_0011, o_part_body_length;
	logic [31:0]	o_single_reply_kind, o_single_reply_port;
	logic [31:0]	o_group_reply_kind, o_group_reply_port;
	logic [95:0]	i_local_id_prefix = 96'h5, o_sender_id_prefix;
	logic [95:0]	o_target_id_prefix;
	logic [127:0]	i_ctx_wdata = 128'h0, i_src_addr = 128'h9;
	logic [127:0]	o_single_reply_addr, o_group_reply_addr;
	logic [63:0]	o_time_mark;
	logic [50:0]	hq[$];
	logic [8:0]	bq[$];
	int	mismatches = 0, checks_done = 0;
	spr_parser i_dut (.*);
	spr_sender i_snd (.i_sys_clk, .i_ready(o_byte_ready),
		.o_valid(i_byte_valid), .o_data(i_byte_data));
	initial forever #20 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		if (o_hdr_valid === 1'b1)
			hq.push_back({o_part_kind_code, o_part_flags, o_byte_order_flag,
				o_part_body_length, o_part_last, o_part_known});
		if (o_body_valid === 1'b1)
			bq.push_back({o_body_end, o_body_byte});
	end
	// ====
	// tasks
	task automatic cmp(string n, logic [767:0] e, logic [767:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s exp %0h got %0h", n, e, g);
		end
	endtask : cmp
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	task automatic wreg(logic [7:0] a, logic [31:0] d);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_reg_wr <= 1'b0;
	endtask : wreg
	task automatic rreg(string n, logic [7:0] a, logic [31:0] e);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_reg_rd <= 1'b0;
		@(negedge i_sys_clk);
		cmp(n, e, o_reg_rdata);
		@(posedge i_sys_clk);
	endtask : rreg
	// message bytes from the top byte down
	task automatic run(int n, logic [95:0] m, int ia);
		hq.delete();
		bq.delete();
		i_msg_start <= 1'b1;
		i_msg_len <= 32'(n);
		@(posedge i_sys_clk);
		i_msg_start <= 1'b0;
		for (int i = 0; i < n; i++) begin
			i_part_invalid <= (i == ia);
			i_snd.send(m[95 - 8 * i -: 8]);
		end
		i_part_invalid <= 1'b0;
		i_snd.rest();
		if (i_snd.hung) begin
			mismatches++;
			conclude();
		end
		@(posedge i_sys_clk);
	endtask : run
	// ====
	// sequence
	int	ln[3] = '{8, 3, 8};
	int	ia[3] = '{99, 99, 5};
	logic [31:0]	es[3] = '{32'h0000_0005, 32'h0000_0003, 32'h0000_0011};
	logic [95:0]	ms[3] = '{96'h0800_0100_1122_3344_0000_0000,
		96'h0701_0000_0000_0000_0000_0000, 96'h1500_0004_1122_3344_0000_0000};
	initial begin
		repeat (20) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
		wreg(REG_MASK, 32'h0000_0008);
		i_ctx_wr <= 1'b1;
		i_ctx_sel <= SEL_TIME;
		i_ctx_wdata <= 128'h1234;
		@(posedge i_sys_clk);
		i_ctx_wr <= 1'b0;
		@(negedge i_sys_clk);
		cmp("time", 65'h1_0000_0000_0000_1234, {o_time_mark_present,
			o_time_mark});
		@(posedge i_sys_clk);
		run(12, 96'h15E1_0200_AABB_55F1_0000_CCDD, 99);
		cmp("hdr0", {KIND_DATA, 8'h01, 1'b1, 32'h2, 2'b01}, hq[0]);
		cmp("hdr1", {16'h5501, 1'b1, 32'h2, 2'b10}, hq[1]);
		cmp("ctx", {VERSION_CURRENT, MAKER_CODE_NONE, ID_PREFIX_NONE,
			i_local_id_prefix, i_xport_kind, i_src_addr, PORT_INVALID,
			i_xport_kind, ADDR_INVALID, PORT_INVALID, 1'b0, TIME_INVALID},
			{o_sender_protocol_version, o_sender_maker_code,
			o_sender_id_prefix, o_target_id_prefix, o_single_reply_kind,
			o_single_reply_addr, o_single_reply_port, o_group_reply_kind,
			o_group_reply_addr, o_group_reply_port, o_time_mark_present,
			o_time_mark});
		cmp("irq", 1'b1, o_irq);
		cmp("body", {32'h0000_0002, 9'h0AA, 9'h1BB},
			{32'(bq.size()), bq[0], bq[1]});
		rreg("parts", REG_PARTS, 32'h0000_0002);
		rreg("status", REG_STATUS, 32'h0000_0009);
		wreg(REG_STATUS, 32'h0000_0008);
		@(negedge i_sys_clk);
		cmp("irq", 1'b0, o_irq);
		@(posedge i_sys_clk);
		rreg("unmapped", 8'h10, 32'h0000_0000);
		wreg(REG_STATUS, 32'h0000_001F);
		// no sender address from here on
		i_src_addr_ok <= 1'b0;
		foreach (ln[k]) begin
			run(ln[k], ms[k], ia[k]);
			rreg("status", REG_STATUS, es[k]);
			wreg(REG_STATUS, 32'h0000_001F);
		end
		cmp("hdr4", {KIND_DATA, 9'h0, 32'h4, 2'b11}, hq[0]);
		cmp("body4", {32'h0000_0001, 9'h011},
			{32'(bq.size()), bq[0]});
		cmp("uc addr", ADDR_INVALID, o_single_reply_addr);
		// start is ignored while disabled
		wreg(REG_CTRL, 32'h0000_0000);
		i_msg_start <= 1'b1;
		@(posedge i_sys_clk);
		i_msg_start <= 1'b0;
		rreg("ignored", REG_PARTS, 32'h0000_0001);
		rreg("ctrl", REG_CTRL, 32'h0000_0000);
		conclude();
	end
endmodule : spr_parser_tb
